// ### clkc_cfg.svh
// Register offsets, field positions, reset values and notes for the clock controller
// Notes on behaviour
// (R1) Gate bit 1 passes clock; resets 1
// (R2) Four gates use system bus clock
// (R3) Real-time timer runs with gate off
// (R4) Sleep request bit starts sleep; resets 0
// (R5) Idle bit stays set until software clears
// (R6) Idle entered only after core acknowledge
// (R7) USB clock off stops clock and PLL
// (R8) USB lock wait counts upper lock field
// (R9) Main PLL off only in slow mode
// (R10) Software waits PLL settle before leaving slow
// (R11) Slow bit picks input source over PLL
// (R12) Slow core clock: input over twice divider
// (R13) Slow input is crystal or external clock
// (R14) USB halve bit divides USB clock by two
// (R15) Software picks halving for 48MHz USB clock
// (R16) System ratio codes 00, 01 give /1, /2
// (R17) Code 10 gives /4, or /8 halved
// (R18) Code 11 gives /3, or /6 halved
// (R19) Peripheral clock is system or half of it
// (R20) Scaling bit runs core on system clock
// (R21) Camera select picks raw or divided clock
// (R22) Camera divide is twice factor plus one
// (R23) Ratio and source changes never make runts
`ifndef CLKC_CFG_SVH
`define CLKC_CFG_SVH
`define CLKC_OFF_LOCK 32'h4c000000
`define CLKC_OFF_GATE 32'h4c00000c
`define CLKC_OFF_SLOW 32'h4c000010
`define CLKC_OFF_DIV 32'h4c000014
`define CLKC_OFF_CAM 32'h4c000018
`define CLKC_OFF_SRC 32'h4c00001c
`define CLKC_RST_LOCK 32'hffffffff
`define CLKC_RST_GATE 24'hfffff0
`define CLKC_WM_GATE 24'h1ffffc
`define CLKC_RST_SLOW 8'h04
`define CLKC_WM_SLOW 8'hb7
`define CLKC_WM_DIV 4'hf
`define CLKC_WM_CAM 13'h131f
`define CLKC_B_SLEEP 3
`define CLKC_B_IDLE 2
`define CLKC_B_USBOFF 7
`define CLKC_B_MPLLOFF 5
`define CLKC_B_SLOW 4
`define CLKC_B_USBHALF 3
`define CLKC_B_PRATIO 0
`define CLKC_B_DVS 12
`define CLKC_B_Q_HALF 9
`define CLKC_B_T_HALF 8
`define CLKC_B_CAMSEL 4
`endif

// ### clkc_core_model.sv
// Core wrapper model that answers idle requests after a set delay
`timescale 1ns/10ps
module clkc_core_model (
  input  wire logic       clk_in,      // System clock
  input  wire logic       rst_in,      // Async reset, high
  input  wire logic       idle_req_in, // Idle request level
  input  wire logic [7:0] delay_in,    // Cycles before acknowledge
  output logic            idle_ack_out // Acknowledge level
);
  logic [7:0] wait_reg; // Cycles the request has stood
  // A slow wrapper shows whether idle really waits for us
  // ack after delay
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_reg     <= 8'h00;
      idle_ack_out <= 1'b0;
    end else if (!idle_req_in) begin // Withdrawn at once
      wait_reg     <= 8'h00;
      idle_ack_out <= 1'b0;
    end else begin
      if (wait_reg != 8'hff) wait_reg <= wait_reg + 8'h01;
      idle_ack_out <= (wait_reg >= delay_in);
    end
  end
endmodule

// ### clkc_pkg.sv
// Types shared by the clock controller
package clkc_pkg;
  // Source clock enables, one-cycle pulses
  typedef struct packed {
    logic xtal;
    logic ext;
    logic main_pll;
    logic upll;
  } clkc_src_t;
  // Derived clock enables
  typedef struct packed {
    logic core;
    logic cpu;
    logic sys;
    logic per;
    logic usb;
    logic cam;
  } clkc_tick_t;
  // Power mode, Gray along run, wait, idle
  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_WAIT  = 2'b01,
    PM_IDLE  = 2'b11,
    PM_SLEEP = 2'b10
  } clkc_pm_t;
endpackage

// ### clkc_top.sv
// Clock gating and divider controller with register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "clkc_cfg.svh"
module clkc_top (
  input  wire logic                 clk_in,           // 20 MHz
  input  wire logic                 rst_in,           // Async, high
  input  wire logic [31:0]          addr_in,          // Register address
  input  wire logic [31:0]          wdata_in,         // Write data
  input  wire logic                 wr_in,            // Write strobe
  input  wire logic                 rd_in,            // Read strobe
  input  wire clkc_pkg::clkc_src_t  src_in,           // Source enables
  input  wire logic                 idle_ack_in,      // Core idle acknowledge
  output logic [31:0]               rdata_out,        // Read data
  output clkc_pkg::clkc_tick_t      tick_out,         // Derived enables
  output logic [3:0]                sys_gate_out,     // Camera, host, display, flash
  output logic [12:0]               per_gate_out,     // Bits 20, 18..7
  output logic                      rtc_timer_out,    // Ungated timer tick
  output logic                      main_pll_pwr_out, // Main PLL power
  output logic                      usb_pll_pwr_out,  // USB PLL power
  output logic                      idle_req_out,     // Idle request level
  output logic                      sleep_req_out     // Sleep request level
);
  import clkc_pkg::*;

  // Divider step: returns pulse, next count, next divisor
  function automatic logic [12:0] div_step(input logic tick, input logic [5:0] cnt,
                                           input logic [5:0] act, input logic [5:0] req);
    logic [12:0] r;
    r = {1'b0, cnt, act};
    if (tick) begin
      // New divisor only at wrap, so no runt period
      if (cnt >= act - 6'h01) begin
        r = {1'b1, 6'h00, req};
      end else begin
        r = {1'b0, cnt + 6'h01, act};
      end
    end
    return r;
  endfunction

  // Software registers
  logic [31:0] lock_reg, lock_next;   // Lock counts
  logic [23:0] gate_reg, gate_next;   // Gates and mode requests
  logic [7:0]  slow_reg, slow_next;   // Slow mode control
  logic [3:0]  div_reg, div_next;     // Bus ratios
  logic [12:0] cam_reg, cam_next;     // Camera divider
  logic        esel_reg, esel_next;   // External source select
  logic [31:0] rdata_next;
  // Divider state: count and active divisor per chain
  logic [5:0]  c_cnt_reg, c_cnt_next, c_act_reg, c_act_next;
  logic [5:0]  s_cnt_reg, s_cnt_next, s_act_reg, s_act_next;
  logic [5:0]  p_cnt_reg, p_cnt_next, p_act_reg, p_act_next;
  logic [5:0]  u_cnt_reg, u_cnt_next, u_act_reg, u_act_next;
  logic [5:0]  m_cnt_reg, m_cnt_next, m_act_reg, m_act_next;
  logic        csel_reg, csel_next;   // Core source in use
  logic        dvs_reg, dvs_next;     // Core-on-bus in use
  logic [15:0] ulk_cnt_reg, ulk_cnt_next; // USB lock counter
  logic        ulk_reg, ulk_next;     // USB PLL locked
  clkc_pm_t    pm_reg, pm_next;       // Power mode
  // Output images
  clkc_tick_t  tick_next;
  logic [3:0]  sysg_next;
  logic [12:0] perg_next;
  logic        rtc_next, mpwr_next, upwr_next;
  // Combinational helpers
  logic        in_tick, core_src, upll_live, run;
  logic [12:0] c_s, s_s, p_s, u_s, m_s;
  logic [5:0]  c_req, s_req, p_req, u_req, m_req;

  // Register writes, reads, modes and all clock chains
  always_comb begin
    lock_next  = lock_reg;
    gate_next  = gate_reg;
    slow_next  = slow_reg;
    div_next   = div_reg;
    cam_next   = cam_reg;
    esel_next  = esel_reg;
    rdata_next = 32'h00000000;
    pm_next    = pm_reg;
    // Register writes, masked to defined bits
    if (wr_in) begin
      case (addr_in)
        `CLKC_OFF_LOCK: lock_next = wdata_in;
        // (R1) gate bits writable
        `CLKC_OFF_GATE: gate_next = (gate_reg & ~`CLKC_WM_GATE) | (wdata_in[23:0] & `CLKC_WM_GATE);
        `CLKC_OFF_SLOW: slow_next = wdata_in[7:0] & `CLKC_WM_SLOW;
        `CLKC_OFF_DIV:  div_next  = wdata_in[3:0] & `CLKC_WM_DIV;
        `CLKC_OFF_CAM:  cam_next  = wdata_in[12:0] & `CLKC_WM_CAM;
        `CLKC_OFF_SRC:  esel_next = wdata_in[0];
        default: ;
      endcase
    end
    // Reads; unmapped addresses read zero
    if (rd_in) begin
      case (addr_in)
        `CLKC_OFF_LOCK: rdata_next = lock_reg;
        `CLKC_OFF_GATE: rdata_next = {8'h00, gate_reg};
        `CLKC_OFF_SLOW: rdata_next = {24'h000000, slow_reg};
        `CLKC_OFF_DIV:  rdata_next = {28'h0000000, div_reg};
        `CLKC_OFF_CAM:  rdata_next = {19'h00000, cam_reg};
        `CLKC_OFF_SRC:  rdata_next = {21'h000000, pm_reg, ulk_reg, 7'h00, esel_reg};
        default:        rdata_next = 32'h00000000;
      endcase
    end
    // Power mode sequencing; sleep leaves only by reset
    case (pm_reg)
      PM_RUN: begin
        // (R4) sleep request starts sleep
        if (gate_reg[`CLKC_B_SLEEP]) begin
          pm_next = PM_SLEEP;
        // (R5) idle request level
        end else if (gate_reg[`CLKC_B_IDLE]) begin
          pm_next = PM_WAIT;
        end
      end
      PM_WAIT: begin
        // (R6) wait for core acknowledge
        if (!gate_reg[`CLKC_B_IDLE]) begin
          pm_next = PM_RUN;
        end else if (idle_ack_in) begin
          pm_next = PM_IDLE;
        end
      end
      PM_IDLE: begin
        // Bit is never self-cleared; software ends idle
        if (!gate_reg[`CLKC_B_IDLE]) begin
          pm_next = PM_RUN;
        end
      end
      PM_SLEEP: pm_next = PM_SLEEP;
      default:  pm_next = PM_RUN;
    endcase
    run = (pm_reg != PM_SLEEP);
    // (R13) slow input from crystal or external
    in_tick = esel_reg ? src_in.ext : src_in.xtal;
    // (R11) core source: input in slow mode
    core_src = csel_reg ? in_tick : src_in.main_pll;
    // (R12) slow divisor twice value, or one
    c_req = (slow_next[`CLKC_B_SLOW] && slow_reg[2:0] != 3'h0) ? {2'b00, slow_reg[2:0], 1'b0} : 6'h01;
    c_s = div_step(core_src & run, c_cnt_reg, c_act_reg, c_req);
    // (R23) source switch only at a core edge
    csel_next = c_s[12] ? slow_reg[`CLKC_B_SLOW] : csel_reg;
    // (R16) (R17) (R18) system bus ratio
    case (div_reg[2:1])
      2'b00:   s_req = 6'h01;
      2'b01:   s_req = 6'h02;
      2'b10:   s_req = cam_reg[`CLKC_B_Q_HALF] ? 6'h08 : 6'h04;
      default: s_req = cam_reg[`CLKC_B_T_HALF] ? 6'h06 : 6'h03;
    endcase
    s_s = div_step(c_s[12], s_cnt_reg, s_act_reg, s_req);
    // (R19) peripheral bus ratio
    p_req = div_reg[`CLKC_B_PRATIO] ? 6'h02 : 6'h01;
    p_s = div_step(s_s[12], p_cnt_reg, p_act_reg, p_req);
    // (R20) cpu tick follows system clock when scaling
    dvs_next = s_s[12] ? cam_reg[`CLKC_B_DVS] : dvs_reg;
    // (R7) (R8) lock wait after USB PLL turn-on
    ulk_cnt_next = ulk_cnt_reg;
    ulk_next = ulk_reg;
    if (slow_reg[`CLKC_B_USBOFF]) begin
      ulk_cnt_next = 16'h0000;
      ulk_next = 1'b0;
    end else if (!ulk_reg && in_tick) begin
      if (ulk_cnt_reg >= lock_reg[31:16]) begin
        ulk_next = 1'b1;
      end else begin
        ulk_cnt_next = ulk_cnt_reg + 16'h0001;
      end
    end
    upll_live = src_in.upll & ulk_reg & ~slow_reg[`CLKC_B_USBOFF] & run;
    // (R14) USB clock halving
    u_req = div_reg[`CLKC_B_USBHALF] ? 6'h02 : 6'h01;
    u_s = div_step(upll_live, u_cnt_reg, u_act_reg, u_req);
    // (R21) (R22) camera divided or raw
    // Factor plus one is worked at five bits so a factor of 15 gives 32, not 0
    m_req = cam_reg[`CLKC_B_CAMSEL] ? {({1'b0, cam_reg[3:0]} + 5'h01), 1'b0} : 6'h01;
    m_s = div_step(upll_live, m_cnt_reg, m_act_reg, m_req);
    {c_cnt_next, c_act_next} = c_s[11:0];
    {s_cnt_next, s_act_next} = s_s[11:0];
    {p_cnt_next, p_act_next} = p_s[11:0];
    {u_cnt_next, u_act_next} = u_s[11:0];
    {m_cnt_next, m_act_next} = m_s[11:0];
    tick_next.core = c_s[12];
    tick_next.cpu  = (dvs_reg ? s_s[12] : c_s[12]) & (pm_reg == PM_RUN || pm_reg == PM_WAIT);
    tick_next.sys  = s_s[12];
    tick_next.per  = p_s[12];
    tick_next.usb  = u_s[12];
    tick_next.cam  = m_s[12];
    // (R1) (R2) gates on system and peripheral clocks
    sysg_next = {gate_reg[19], gate_reg[6], gate_reg[5], gate_reg[4]} & {4{s_s[12]}};
    perg_next = {gate_reg[20], gate_reg[18:7]} & {13{p_s[12]}};
    // (R3) timer tick ignores gate and sleep
    rtc_next = in_tick;
    // (R9) main PLL off only in slow mode
    mpwr_next = !(slow_reg[`CLKC_B_MPLLOFF] && slow_reg[`CLKC_B_SLOW]);
    upwr_next = !slow_reg[`CLKC_B_USBOFF];
  end

  // State registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_reg <= `CLKC_RST_LOCK;
      gate_reg <= `CLKC_RST_GATE;
      slow_reg <= `CLKC_RST_SLOW;
      div_reg <= 4'h0;
      cam_reg <= 13'h0000;
      esel_reg <= 1'b0;
      rdata_out <= 32'h00000000;
      {c_cnt_reg, s_cnt_reg, p_cnt_reg, u_cnt_reg, m_cnt_reg} <= 30'h00000000;
      {c_act_reg, s_act_reg, p_act_reg, u_act_reg, m_act_reg} <= {5{6'h01}};
      csel_reg <= 1'b0;
      dvs_reg <= 1'b0;
      ulk_cnt_reg <= 16'h0000;
      ulk_reg <= 1'b0;
      pm_reg <= PM_RUN;
      tick_out <= '0;
      sys_gate_out <= 4'h0;
      per_gate_out <= 13'h0000;
      rtc_timer_out <= 1'b0;
      main_pll_pwr_out <= 1'b1;
      usb_pll_pwr_out <= 1'b1;
      idle_req_out <= 1'b0;
      sleep_req_out <= 1'b0;
    end else begin
      lock_reg <= lock_next;
      gate_reg <= gate_next;
      slow_reg <= slow_next;
      div_reg <= div_next;
      cam_reg <= cam_next;
      esel_reg <= esel_next;
      rdata_out <= rdata_next;
      {c_cnt_reg, s_cnt_reg, p_cnt_reg, u_cnt_reg, m_cnt_reg} <=
        {c_cnt_next, s_cnt_next, p_cnt_next, u_cnt_next, m_cnt_next};
      {c_act_reg, s_act_reg, p_act_reg, u_act_reg, m_act_reg} <=
        {c_act_next, s_act_next, p_act_next, u_act_next, m_act_next};
      csel_reg <= csel_next;
      dvs_reg <= dvs_next;
      ulk_cnt_reg <= ulk_cnt_next;
      ulk_reg <= ulk_next;
      pm_reg <= pm_next;
      tick_out <= tick_next;
      sys_gate_out <= sysg_next;
      per_gate_out <= perg_next;
      rtc_timer_out <= rtc_next;
      main_pll_pwr_out <= mpwr_next;
      usb_pll_pwr_out <= upwr_next;
      idle_req_out <= gate_reg[`CLKC_B_IDLE];
      sleep_req_out <= gate_reg[`CLKC_B_SLEEP];
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_usb_off_held;
    slow_reg[`CLKC_B_USBOFF] [*2];
  endsequence
  sequence s_gate_off_held;
    !gate_reg[4] [*2];
  endsequence
  AST_USB_OFF: assert property (s_usb_off_held |-> !tick_out.usb) // (R7)
    else $error("usb clock ticks while off");
  AST_GATE_OFF: assert property (s_gate_off_held |-> !sys_gate_out[0]) // (R1)
    else $error("gated flash clock still ticks");
  AST_PLL_ON: assert property (!slow_reg[`CLKC_B_SLOW] [*2] |-> main_pll_pwr_out) // (R9)
    else $error("main pll off outside slow mode");
  AST_RTC_ALIVE: assert property (src_in.xtal && !esel_reg |=> rtc_timer_out) // (R3)
    else $error("timer tick lost");
  AST_IDLE_ACK: assert property ($rose(pm_reg == PM_IDLE) |-> $past(idle_ack_in)) // (R6)
    else $error("idle entered without acknowledge");
  AST_IDLE_HOLD: assert property (gate_reg[`CLKC_B_IDLE] && !wr_in |=> gate_reg[`CLKC_B_IDLE]) // (R5)
    else $error("idle bit cleared by hardware");
  AST_PER_SUB: assert property (tick_out.per |-> tick_out.sys) // (R19)
    else $error("peripheral tick without system tick");
  AST_SYS_HALF: assert property (tick_out.sys && s_act_reg == 6'h02 && $past(s_act_reg == 6'h02) && $past(tick_out.sys) |-> 0) // (R16)
    else $error("half ratio ticks on consecutive core ticks");
  AST_SLEEP_STOP: assert property (pm_reg == PM_SLEEP |=> !tick_out.cpu && !tick_out.core) // (R4)
    else $error("clocks run in sleep");
endmodule

// ### tb.sv
// Self-checking bench for the clock controller
`timescale 1ns/10ps
`include "clkc_cfg.svh"
module tb;
  import clkc_pkg::*;
  logic              clk_in = 1'b0;  // 20 MHz
  logic              rst_in = 1'b0;  // Raised at time zero
  logic [31:0]       addr_in = '0;   // Bus address
  logic [31:0]       wdata_in = '0;  // Bus write data
  logic              wr_in = 1'b0;   // Write strobe
  logic              rd_in = 1'b0;   // Read strobe
  logic              ext_tgl = 1'b0; // External input runs at half rate
  logic [7:0]        ack_delay = '0; // Wrapper answer delay
  clkc_src_t         src_in = '0;    // Source pulses
  clkc_tick_t        tick_out;       // Derived ticks
  logic [31:0]       rdata_out, r, g;
  logic [3:0]        sys_gate_out, sg;
  logic [12:0]       per_gate_out, pg;
  logic              rtc_timer_out, main_pll_pwr_out, usb_pll_pwr_out, idle_req_out, sleep_req_out, idle_ack_in, rt;
  int                n_errors = 0, cmp_count = 0, p, v, e;
  clkc_top DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .src_in(src_in), .idle_ack_in(idle_ack_in), .rdata_out(rdata_out), .tick_out(tick_out),
    .sys_gate_out(sys_gate_out), .per_gate_out(per_gate_out), .rtc_timer_out(rtc_timer_out),
    .main_pll_pwr_out(main_pll_pwr_out), .usb_pll_pwr_out(usb_pll_pwr_out), .idle_req_out(idle_req_out),
    .sleep_req_out(sleep_req_out));
  clkc_core_model core (.clk_in(clk_in), .rst_in(rst_in), .idle_req_in(idle_req_out), .delay_in(ack_delay),
    .idle_ack_out(idle_ack_in));
  always #25 clk_in = ~clk_in;
  // Both PLLs and the crystal pulse every cycle, external every other
  always @(posedge clk_in) begin
    ext_tgl <= ~ext_tgl;
    src_in  <= '{xtal: 1'b1, ext: ext_tgl, main_pll: 1'b1, upll: 1'b1};
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask
  // Pulse spacing of one tick; early pulses skipped since a new divisor waits for a wrap
  task automatic period(input int sel, output int n);
    logic [5:0] t;
    int k;
    for (int s = 0; s < 3; s++) begin
      k = 0;
      do begin
        @(negedge clk_in);
        t = tick_out;
        k++;
      end while (t[sel] !== 1'b1 && k < 300);
      n = k;
    end
  endtask
  function automatic int sys_div(input logic [1:0] c, input logic h);
    case (c)
      2'b00: return 1;
      2'b01: return 2;
      2'b10: return h ? 8 : 4;
      default: return h ? 6 : 3;
    endcase
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(73));
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`CLKC_OFF_GATE, r);
    check(r, 32'h00fffff0);
    rd(`CLKC_OFF_SLOW, r);
    check(r, 32'h00000004);
    rd(32'h4c000020, r);
    check(r, 32'h0);
    // Every ratio code with both halving bits, peripheral ratios and scaling
    for (int c = 0; c < 16; c++) begin
      v = $urandom % 2;
      wr(`CLKC_OFF_CAM, {19'h0, v[0], 2'b00, c[3], c[3], 8'h00});
      wr(`CLKC_OFF_DIV, {29'h0, c[1:0], c[2]});
      e = sys_div(c[1:0], c[3]);
      period(3, p);
      check(p, e);
      period(2, p);
      check(p, c[2] ? 2 * e : e);
      period(4, p);
      check(p, v ? e : 1);
    end
    // Slow mode from both inputs, zero divider first
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 0 : $urandom % 8;
      wr(`CLKC_OFF_SRC, {31'h0, i[0]});
      wr(`CLKC_OFF_SLOW, {24'h0, 5'b00010, v[2:0]});
      period(5, p);
      check(p, (v ? 2 * v : 1) * (i[0] ? 2 : 1));
    end
    wr(`CLKC_OFF_SLOW, 32'h20);
    repeat (3) @(negedge clk_in);
    check(main_pll_pwr_out, 1'b1);
    wr(`CLKC_OFF_SLOW, 32'h30);
    repeat (3) @(negedge clk_in);
    check(main_pll_pwr_out, 1'b0);
    wr(`CLKC_OFF_SLOW, 32'h10);
    // settle wait before leaving slow mode
    repeat (6000) @(posedge clk_in);
    wr(`CLKC_OFF_SLOW, 32'h00);
    wr(`CLKC_OFF_LOCK, 32'h00400000);
    wr(`CLKC_OFF_SLOW, 32'h80);
    repeat (3) @(negedge clk_in);
    check(usb_pll_pwr_out, 1'b0);
    wr(`CLKC_OFF_SLOW, 32'h00);
    rd(`CLKC_OFF_SRC, r);
    check(r[8], 1'b0);
    check(usb_pll_pwr_out, 1'b1);
    repeat (200) @(posedge clk_in);
    rd(`CLKC_OFF_SRC, r);
    check(r[8], 1'b1);
    // USB halving and camera divider; halving suits a double-rate PLL
    for (int i = 0; i < 4; i++) begin
      v = $urandom % 16;
      wr(`CLKC_OFF_DIV, {28'h0, i[0], 3'h0});
      wr(`CLKC_OFF_CAM, {27'h0, i[1], v[3:0]});
      period(1, p);
      check(p, i[0] ? 2 : 1);
      period(0, p);
      check(p, i[1] ? 2 * (v + 1) : 1);
    end
    // Random gate patterns, timer control gate closed in the first
    for (int i = 0; i < 4; i++) begin
      g = $urandom & 32'h001ffff0;
      if (i == 0) g[14] = 1'b0;
      wr(`CLKC_OFF_GATE, g);
      rd(`CLKC_OFF_GATE, r);
      check(r, g | 32'h00e00000);
      repeat (10) @(negedge clk_in);
      sg = '0;
      pg = '0;
      rt = 1'b0;
      repeat (20) begin
        @(negedge clk_in);
        sg |= sys_gate_out;
        pg |= per_gate_out;
        rt |= rtc_timer_out;
      end
      check(sg, {g[19], g[6:4]});
      check(pg, {g[20], g[18:7]});
      check(rt, 1'b1);
    end
    // Idle with a slow then a prompt wrapper
    for (int i = 0; i < 2; i++) begin
      ack_delay <= i ? 8'h00 : 8'h14;
      wr(`CLKC_OFF_GATE, 32'h4);
      rd(`CLKC_OFF_SRC, r);
      if (i == 0) check(r[10:9], 2'b01);
      repeat (40) @(negedge clk_in);
      rd(`CLKC_OFF_SRC, r);
      check(r[10:9], 2'b11);
      check(idle_req_out, 1'b1);
      period(4, p);
      check(p, 300);
      wr(`CLKC_OFF_GATE, 32'h0);
      rd(`CLKC_OFF_SRC, r);
      check(r[10:9], 2'b00);
    end
    wr(`CLKC_OFF_GATE, 32'h8);
    repeat (3) @(negedge clk_in);
    check(sleep_req_out, 1'b1);
    rd(`CLKC_OFF_SRC, r);
    check(r[10:9], 2'b10);
    give_verdict();
  end
endmodule
